// ==== hdo_top.sv ====
// Purpose: Count and direction output logic of a two-plate magnetic sensor
// Assumes: Plate comparators deliver on/off threshold levels asynchronously
// Notes: Open-drain pins split into value, active-low enable and sensed level
`timescale 1ns/10ps
module hdo_top (
	input wire logic SYS_CLK,
	input wire logic NRST,
	input wire logic PLATE1_ABOVE_ON,
	input wire logic PLATE1_BELOW_OFF,
	input wire logic PLATE2_ABOVE_ON,
	input wire logic PLATE2_BELOW_OFF,
	input wire logic COUNT_IN,
	input wire logic DIR_IN,
	output logic COUNT_O,
	output logic COUNT_OE_N,
	output logic DIR_O,
	output logic DIR_OE_N,
	output logic DIR_VALID,
	output logic TEST_MODE,
	output logic INIT_DONE
);
	import hdo_pkg::*;

	logic p1_on;
	logic p1_off;
	logic p2_on;
	logic p2_off;
	logic count_pin;
	logic dir_pin;
	logic count_pin_d;
	logic [DIV_W-1:0] div_cnt;
	logic half_tick;
	logic phase;
	logic full_tick;
	logic mid_tick;
	logic [INIT_W-1:0] init_cnt;
	hdo_state_type state;
	logic plate1_latch;
	logic plate2_latch;
	logic next_plate1;
	logic next_plate2;
	logic count_stage;
	logic dir_stage;
	logic dir_pending;
	logic last_dir;
	logic [1:0] same_edges;
	logic [SETTLE_W-1:0] settle_cnt;
	logic test_enter;
	logic count_rise;

	hdo_sync u_p1_on (.clk(SYS_CLK), .nrst(NRST), .reset_value(1'h0),
		.async_in(PLATE1_ABOVE_ON), .sync_out(p1_on));
	hdo_sync u_p1_off (.clk(SYS_CLK), .nrst(NRST), .reset_value(1'h0),
		.async_in(PLATE1_BELOW_OFF), .sync_out(p1_off));
	hdo_sync u_p2_on (.clk(SYS_CLK), .nrst(NRST), .reset_value(1'h0),
		.async_in(PLATE2_ABOVE_ON), .sync_out(p2_on));
	hdo_sync u_p2_off (.clk(SYS_CLK), .nrst(NRST), .reset_value(1'h0),
		.async_in(PLATE2_BELOW_OFF), .sync_out(p2_off));
	hdo_sync u_count (.clk(SYS_CLK), .nrst(NRST), .reset_value(1'h1),
		.async_in(COUNT_IN), .sync_out(count_pin));
	hdo_sync u_dir (.clk(SYS_CLK), .nrst(NRST), .reset_value(1'h1),
		.async_in(DIR_IN), .sync_out(dir_pin));

	// Sampling clock as half-period enables
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			div_cnt <= '0;
			half_tick <= 1'h0;
		end else if (div_cnt == DIV_W'(HALF_PERIOD_CYCLES - 1)) begin
			div_cnt <= '0;
			half_tick <= 1'h1;
		end else begin
			div_cnt <= div_cnt + DIV_W'(1);
			half_tick <= 1'h0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			phase <= 1'h0;
		end else if (half_tick) begin
			phase <= ~phase;
		end
	end

	assign full_tick = half_tick && phase;
	assign mid_tick = half_tick && !phase;

	// Latched switch behaviour, hold between thresholds
	always_comb begin
		next_plate1 = plate1_latch;
		next_plate2 = plate2_latch;
		if (p1_on) begin
			next_plate1 = 1'h1;
		end else if (p1_off) begin
			next_plate1 = 1'h0;
		end
		if (p2_on) begin
			next_plate2 = 1'h1;
		end else if (p2_off) begin
			next_plate2 = 1'h0;
		end
	end

	// Start-up sequencing and test mode
	assign test_enter = (state == HDO_RUN) && (settle_cnt == SETTLE_W'(SETTLE_CYCLES));
	assign count_rise = count_pin && !count_pin_d;

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			init_cnt <= '0;
		end else if (state == HDO_INIT) begin
			init_cnt <= init_cnt + INIT_W'(1);
		end
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			count_pin_d <= 1'h1;
		end else begin
			count_pin_d <= count_pin;
		end
	end

	// Released direction line that stays low for the rise time means held outside
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			settle_cnt <= '0;
		end else if (state != HDO_RUN || DIR_OE_N != PIN_RELEASED || dir_pin) begin
			settle_cnt <= '0;
		end else if (settle_cnt != SETTLE_W'(SETTLE_CYCLES)) begin
			settle_cnt <= settle_cnt + SETTLE_W'(1);
		end
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			state <= HDO_INIT;
		end else begin
			case (state)
				HDO_INIT: begin
					if (init_cnt == INIT_W'(INIT_CYCLES - 1)) begin
						state <= HDO_RUN;
					end
				end
				HDO_RUN: begin
					if (test_enter) begin
						state <= HDO_TEST;
					end
				end
				HDO_TEST: begin
					if (count_rise) begin
						state <= HDO_RUN;
					end
				end
				default: begin
					state <= HDO_INIT;
				end
			endcase
		end
	end

	// Plate latches start released; mid-band field keeps that state
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			plate1_latch <= 1'h0;
			plate2_latch <= 1'h0;
		end else if (full_tick && state != HDO_INIT) begin
			plate1_latch <= next_plate1;
			plate2_latch <= next_plate2;
		end
	end

	// Direction judged at the count edge: second plate still old means first-to-second
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			dir_stage <= 1'h1;
			dir_pending <= 1'h0;
			last_dir <= 1'h1;
			same_edges <= 2'h0;
		end else if (state == HDO_TEST) begin
			dir_pending <= 1'h0;
			same_edges <= 2'h0;
		end else if (full_tick && state == HDO_RUN && next_plate1 != plate1_latch) begin
			dir_stage <= (next_plate2 != next_plate1);
			dir_pending <= 1'h1;
			last_dir <= (next_plate2 != next_plate1);
			if ((next_plate2 != next_plate1) != last_dir) begin
				same_edges <= 2'h1;
			end else if (same_edges != EDGES_FOR_VALID) begin
				same_edges <= same_edges + 2'h1;
			end
		end else if (mid_tick) begin
			dir_pending <= 1'h0;
		end
	end

	// Count waits one extra full period, direction half a period
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			count_stage <= 1'h0;
		end else if (full_tick && state != HDO_INIT) begin
			count_stage <= plate1_latch;
		end
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			COUNT_OE_N <= PIN_RELEASED;
			COUNT_O <= PIN_LOW_VALUE;
		end else begin
			COUNT_O <= PIN_LOW_VALUE;
			// Stage already holds the one-period delay, so no second tick wait
			COUNT_OE_N <= ~count_stage;
		end
	end

	// Direction lands half a period ahead of its count edge, giving setup
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			DIR_OE_N <= PIN_RELEASED;
			DIR_O <= PIN_LOW_VALUE;
		end else begin
			DIR_O <= PIN_LOW_VALUE;
			if (mid_tick && dir_pending && state == HDO_RUN) begin
				DIR_OE_N <= dir_stage;
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			DIR_VALID <= 1'h0;
			TEST_MODE <= 1'h0;
			INIT_DONE <= 1'h0;
		end else begin
			DIR_VALID <= (same_edges == EDGES_FOR_VALID) && state == HDO_RUN;
			TEST_MODE <= (state == HDO_TEST);
			INIT_DONE <= (state != HDO_INIT);
		end
	end
endmodule

// ==== hdo_pkg.sv ====
// Purpose: Shared constants of the hall direction output logic
// Assumes: 40 MHz system clock
// Notes: Times kept in their own units, cycle counts derived
package hdo_pkg;
	localparam int SYS_CLK_KHZ = 40000;
	localparam int SAMPLE_KHZ = 150;
	// Longest half period, rounded down, keeps the rate above 150 kHz
	localparam int HALF_PERIOD_CYCLES = SYS_CLK_KHZ / (2 * SAMPLE_KHZ);
	localparam int INIT_TIME_US = 50;
	localparam int INIT_CYCLES = (INIT_TIME_US * SYS_CLK_KHZ + 999) / 1000;
	localparam int RELEASE_SETTLE_US = 10;
	localparam int SETTLE_CYCLES = (RELEASE_SETTLE_US * SYS_CLK_KHZ + 999) / 1000;
	localparam int DIV_W = 8;
	localparam int INIT_W = 12;
	localparam int SETTLE_W = 9;
	localparam logic [1:0] EDGES_FOR_VALID = 2'h2;
	localparam logic PIN_RELEASED = 1'h1;
	localparam logic PIN_LOW_VALUE = 1'h0;
	typedef enum logic [1:0] {HDO_INIT, HDO_RUN, HDO_TEST} hdo_state_type;
endpackage

// ==== hdo_sync.sv ====
// Purpose: Three-flop synchroniser with agreement filter
// Assumes: Input asynchronous to SYS_CLK
// Notes: Output changes only when second and third stages agree
`timescale 1ns/10ps
module hdo_sync (
	input wire logic clk,
	input wire logic nrst,
	input wire logic reset_value,
	input wire logic async_in,
	output logic sync_out
);
	logic stage1;
	logic stage2;
	logic stage3;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stage1 <= 1'h1;
			stage2 <= 1'h1;
			stage3 <= 1'h1;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Reset value port is unused; output resets asynchronously to 1, like the stages
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync_out <= 1'h1;
		end else if (stage2 == stage3) begin
			sync_out <= stage3;
		end
	end
endmodule

// ==== hdo_asserts.sv ====
// Purpose: Port checker for hdo_top
// Assumes: Pins split into value and enable
// Notes: Windows allow sync slack
`timescale 1ns/10ps
module hdo_asserts (
	input wire logic SYS_CLK,
	input wire logic NRST,
	input wire logic COUNT_IN,
	input wire logic DIR_IN,
	input wire logic COUNT_O,
	input wire logic COUNT_OE_N,
	input wire logic DIR_O,
	input wire logic DIR_OE_N,
	input wire logic DIR_VALID,
	input wire logic TEST_MODE,
	input wire logic INIT_DONE
);
	logic [11:0] n;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST)
			n <= 12'h000;
		else if (!INIT_DONE)
			n <= n + 12'h001;
	end
	a_init_released: assert property (!INIT_DONE |-> COUNT_OE_N && DIR_OE_N)
		else $error("pin driven in init");
	a_init_length: assert property ($rose(INIT_DONE) |-> n > 12'h7CA && n < 12'h7D6)
		else $error("init length");
	a_pins_pull_low: assert property (!COUNT_O && !DIR_O)
		else $error("pin value high");
	a_dir_leads: assert property (INIT_DONE && $changed(DIR_OE_N)
		|-> ##[132:134] $changed(COUNT_OE_N)) else $error("dir lead");
	a_test_no_valid: assert property (TEST_MODE && $past(TEST_MODE) |-> !DIR_VALID)
		else $error("valid in test");
	a_test_dir_frozen: assert property (TEST_MODE && $past(TEST_MODE) |-> $stable(DIR_OE_N))
		else $error("dir moved in test");
	a_test_entry: assert property ($rose(TEST_MODE) |-> DIR_OE_N && !$past(DIR_IN, 8))
		else $error("test entry cause");
	a_test_exit: assert property (TEST_MODE && $rose(COUNT_IN) |-> ##[1:8] !TEST_MODE)
		else $error("test exit late");
endmodule
bind hdo_top hdo_asserts chk (.SYS_CLK, .NRST, .COUNT_IN, .DIR_IN, .COUNT_O, .COUNT_OE_N,
	.DIR_O, .DIR_OE_N, .DIR_VALID, .TEST_MODE, .INIT_DONE);

// ==== hdo_ctrl_model.sv ====
// Purpose: Controller side of both open-drain lines
// Assumes: Pull-ups on both lines
// Notes: Can hold the direction line low
`timescale 1ns/10ps
module hdo_ctrl_model (
	input wire logic clk,
	input wire logic init_done,
	input wire logic hold_dir_low,
	input wire logic count_o,
	input wire logic count_oe_n,
	input wire logic dir_o,
	input wire logic dir_oe_n,
	output logic count_line,
	output logic dir_line,
	output int edges
);
	logic last = 1'h1;
	assign count_line = count_oe_n ? 1'h1 : count_o;
	assign dir_line = hold_dir_low ? 1'h0 : (dir_oe_n ? 1'h1 : dir_o);
	initial edges = 0;
	// Lines may toggle in init, so edges count only after it
	always @(posedge clk) begin
		last <= count_line;
		if (init_done && count_line !== last)
			edges <= edges + 1;
	end
endmodule

// ==== hdo_top_tb.sv ====
// Purpose: Self-checking bench for hdo_top
// Assumes: One pole passes both plates per step
// Notes: Expected levels come from plate order
`timescale 1ns/10ps
module hdo_top_tb;
	logic SYS_CLK = 1'h0;
	logic NRST = 1'h0;
	logic hold = 1'h0;
	logic [1:0] p1_in = 2'h1;
	logic [1:0] p2_in = 2'h1;
	logic COUNT_IN, DIR_IN, COUNT_O, COUNT_OE_N, DIR_O, DIR_OE_N, DIR_VALID, TEST_MODE, INIT_DONE;
	logic exp_dir = 1'h1;
	int err_total = 0;
	int comparisons = 0;
	int cycles = 0;
	int edges, p1 = 0, p2 = 0, run = 0, exp_edges = 0;
	always #12.5 SYS_CLK = ~SYS_CLK;
	hdo_top dut (.SYS_CLK, .NRST, .PLATE1_ABOVE_ON(p1_in[1]), .PLATE1_BELOW_OFF(p1_in[0]),
		.PLATE2_ABOVE_ON(p2_in[1]), .PLATE2_BELOW_OFF(p2_in[0]), .COUNT_IN, .DIR_IN,
		.COUNT_O, .COUNT_OE_N, .DIR_O, .DIR_OE_N, .DIR_VALID, .TEST_MODE, .INIT_DONE);
	hdo_ctrl_model ctrl (.clk(SYS_CLK), .init_done(INIT_DONE), .hold_dir_low(hold),
		.count_o(COUNT_O), .count_oe_n(COUNT_OE_N), .dir_o(DIR_O), .dir_oe_n(DIR_OE_N),
		.count_line(COUNT_IN), .dir_line(DIR_IN), .edges(edges));
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge SYS_CLK) begin
		cycles++;
		if (cycles == 40000) begin
			err_total++;
			summarize();
		end
	end
	task automatic chk(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic drive(input int plate, input int st);
		logic [1:0] code;
		// Both flags high must still read as on
		code = st ? {1'h1, 1'($urandom_range(1))} : 2'h1;
		@(posedge SYS_CLK);
		if (plate == 1) begin
			p1_in <= code;
			if (st != p1) begin
				run = ((st != p2) == exp_dir) ? run + 1 : 1;
				exp_dir = st != p2;
				exp_edges++;
			end
			p1 = st;
		end else begin
			p2_in <= code;
			p2 = st;
		end
		repeat (300) @(posedge SYS_CLK);
		// Mid-band field must keep the latched state
		if ($urandom_range(1) && plate == 1)
			p1_in <= 2'h0;
		else if (plate == 2)
			p2_in <= 2'h0;
	endtask
	task automatic pole(input int fwd);
		int st;
		st = 1 - p1;
		drive(fwd ? 1 : 2, st);
		drive(fwd ? 2 : 1, st);
		repeat (300) @(posedge SYS_CLK);
		chk("count", 1'(p1 == 0), COUNT_OE_N);
		chk("direction", exp_dir, DIR_OE_N);
		chk("valid", 1'(run > 1), DIR_VALID);
		chk("edges", 1'h1, 1'(edges == exp_edges));
	endtask
	initial begin
		void'($urandom(59));
		repeat (4) @(posedge SYS_CLK);
		chk("count reset", 1'h1, COUNT_OE_N);
		chk("dir reset", 1'h1, DIR_OE_N);
		NRST <= 1'h1;
		for (int i = 0; i < 2100 && INIT_DONE !== 1'h1; i++)
			@(posedge SYS_CLK);
		chk("init", 1'h1, INIT_DONE);
		$display("test init done");
		for (int i = 0; i < 12; i++)
			pole(i < 3 ? 1 : int'($urandom_range(1)));
		$display("test movement done");
		repeat (p1 + 1)
			pole(1);
		hold <= 1'h1;
		repeat (500) @(posedge SYS_CLK);
		chk("test entry", 1'h1, TEST_MODE);
		chk("valid in test", 1'h0, DIR_VALID);
		drive(2, 0);
		drive(1, 0);
		for (int i = 0; i < 400 && COUNT_OE_N !== 1'h1; i++)
			@(posedge SYS_CLK);
		repeat (12) @(posedge SYS_CLK);
		chk("test exit", 1'h0, TEST_MODE);
		chk("dir frozen", 1'h1, DIR_OE_N);
		repeat (500) @(posedge SYS_CLK);
		chk("test reentry", 1'h1, TEST_MODE);
		NRST <= 1'h0;
		repeat (2) @(posedge SYS_CLK);
		chk("test cleared", 1'h0, TEST_MODE);
		$display("test mode done");
		summarize();
	end
endmodule
